// ---- design/pmg_defs.svh ----
// constants for the power-management entry ports and status flags
`ifndef PMG_DEFS_SVH
`define PMG_DEFS_SVH

`define PMG_OFF_LEVEL2_CLOCK_STATE      8'h14
`define PMG_OFF_LEVEL3_CLOCK_STATE      8'h15
`define PMG_OFF_GLB       8'h18
`define PMG_OFF_DEV       8'h1C

`define PMG_GLB_IRQ_RSM   11
`define PMG_GLB_EXT_EVT   10
`define PMG_GLB_STBY      8
`define PMG_GLB_GP_SUM    7
`define PMG_GLB_PM_SUM    6
`define PMG_GLB_PWR_CMD   5
`define PMG_GLB_DEV_SUM   4
`define PMG_GLB_MABORT    2
`define PMG_GLB_USB       1
`define PMG_GLB_FW_REL    0

`define PMG_DEV_TRAP_LSB  16
`define PMG_DEV_IDLE_LSB  0
`define PMG_NUM_TRAP      14
`define PMG_NUM_IDLE      12

`define PMG_GLB_W1C_MASK  16'h0D25
`define PMG_RST_GLB       16'h0000
`define PMG_RST_DEV       32'h0000_0000
`define PMG_ENTRY_RDATA   8'h00

`endif

// ---- design/pmg_pkg.sv ----
// types for the power-management entry and status block
package pmg_pkg;

  typedef enum logic [1:0] {
    PMG_RUN,
    PMG_LEVEL2_CLOCK_STATE,
    PMG_LEVEL3_CLOCK_STATE
  } pmg_cstate_t;

  typedef logic [3:0]  pmg_be_t;
  typedef logic [31:0] pmg_word_t;

endpackage : pmg_pkg

// ---- design/pmg_top.sv ----
// level entry ports, global event flags and device monitor flags
`timescale 1ns/1ns
`default_nettype none
`include "pmg_defs.svh"

module pmg_top #(
  parameter int GP_W = 8,
  parameter int PM_W = 8
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // i/o cycle port
  input  wire logic [7:0]         io_addr,
  input  wire logic               io_rd,
  input  wire logic               io_wr,
  input  wire pmg_pkg::pmg_be_t   io_be,
  input  wire pmg_pkg::pmg_word_t io_wdata,
  output var  pmg_pkg::pmg_word_t io_rdata,
  output logic                    io_rvalid,
  // processor control bits
  input  wire logic               clock_ctrl_enable,
  input  wire logic               host_clock_stop_enable,
  input  wire logic               clock_ctrl_break,
  // event sources
  input  wire logic               irq_resume_evt,
  input  wire logic               external_mgmt_int_input_n,
  input  wire logic               standby_expiry_evt,
  input  wire logic               power_command_evt,
  input  wire logic               master_abort_evt,
  input  wire logic               legacy_usb_evt,
  input  wire logic               legacy_usb_pending,
  input  wire logic               global_release_wr,
  input  wire logic [13:0]        monitor_trap_evt,
  input  wire logic [11:0]        monitor_idle_evt,
  // mirrored status registers
  input  wire logic [GP_W-1:0]    general_purpose_status_reg,
  input  wire logic [PM_W-1:0]    pm_event_status_reg,
  // clock control outputs
  output logic                    level2_entry,
  output logic                    level3_entry,
  output logic                    level2_clock_state,
  output logic                    level3_clock_state,
  output logic                    host_clock_stop
);

  import pmg_pkg::*;

  // decode
  logic        hit_entry;
  logic        hit_glb;
  logic        hit_dev;
  logic        rd_level2_clock_state;
  logic        rd_level3_clock_state;
  pmg_word_t   wmask;
  logic [15:0] glb_clr;
  pmg_word_t   dev_clr;

  assign hit_entry = io_addr[7:2] == 6'(`PMG_OFF_LEVEL2_CLOCK_STATE >> 2);
  assign hit_glb   = io_addr[7:2] == 6'(`PMG_OFF_GLB >> 2);
  assign hit_dev   = io_addr[7:2] == 6'(`PMG_OFF_DEV >> 2);

  // entry port lanes: lane 0 is level 2, lane 1 is level 3
  logic lane0_only;
  logic lane1_only;
  logic entry_rd_ok;

  assign lane0_only  = io_be == 4'h1;
  assign lane1_only  = io_be == 4'h2;
  assign entry_rd_ok = io_rd && hit_entry && clock_ctrl_enable;

  // byte reads only; no write path exists for the entry ports
  assign rd_level2_clock_state = entry_rd_ok && lane0_only;
  assign rd_level3_clock_state = entry_rd_ok && lane1_only;

  assign wmask = {{8{io_be[3]}}, {8{io_be[2]}}, {8{io_be[1]}}, {8{io_be[0]}}};

  // write-one-to-clear masks, zeros and reserved bits do nothing
  assign glb_clr = (io_wr && hit_glb) ?
                   (io_wdata[15:0] & wmask[15:0] & `PMG_GLB_W1C_MASK) :
                   16'h0000;

  // external input synchroniser
  logic ext_sync1_r;
  logic ext_sync2_r;
  logic ext_prev_r;
  logic ext_assert;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_sync1_r <= 1'b1;
      ext_sync2_r <= 1'b1;
    end
    else
    begin
      ext_sync1_r <= external_mgmt_int_input_n;
      ext_sync2_r <= ext_sync1_r;
    end
  end

  // falling-edge detect on the synchronised level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ext_prev_r <= 1'b1;
    else
      ext_prev_r <= ext_sync2_r;
  end

  assign ext_assert = ext_prev_r && !ext_sync2_r;

  // hardware set terms by global flag position
  logic [15:0] glb_set;

  always_comb
  begin
    glb_set = 16'h0000;
    glb_set[`PMG_GLB_IRQ_RSM] = irq_resume_evt;
    glb_set[`PMG_GLB_EXT_EVT] = ext_assert;
    glb_set[`PMG_GLB_STBY]    = standby_expiry_evt;
    glb_set[`PMG_GLB_PWR_CMD] = power_command_evt;
    glb_set[`PMG_GLB_MABORT]  = master_abort_evt;
    glb_set[`PMG_GLB_USB]     = legacy_usb_evt;
    glb_set[`PMG_GLB_FW_REL]  = global_release_wr;
  end

  // global event flags
  logic irq_rsm_r;
  logic ext_evt_r;
  logic stby_r;
  logic pwr_cmd_r;
  logic mabort_r;
  logic usb_r;
  logic fw_rel_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_rsm_r <= 1'b0;
    else
      irq_rsm_r <= (irq_rsm_r && !glb_clr[`PMG_GLB_IRQ_RSM])
                   || glb_set[`PMG_GLB_IRQ_RSM];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ext_evt_r <= 1'b0;
    else
      ext_evt_r <= (ext_evt_r && !glb_clr[`PMG_GLB_EXT_EVT])
                   || glb_set[`PMG_GLB_EXT_EVT];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stby_r <= 1'b0;
    else
      stby_r <= (stby_r && !glb_clr[`PMG_GLB_STBY])
                || glb_set[`PMG_GLB_STBY];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pwr_cmd_r <= 1'b0;
    else
      pwr_cmd_r <= (pwr_cmd_r && !glb_clr[`PMG_GLB_PWR_CMD])
                   || glb_set[`PMG_GLB_PWR_CMD];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mabort_r <= 1'b0;
    else
      mabort_r <= (mabort_r && !glb_clr[`PMG_GLB_MABORT])
                  || glb_set[`PMG_GLB_MABORT];
  end

  // cleared only by the usb side dropping its pending status
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      usb_r <= 1'b0;
    else
      usb_r <= (usb_r && legacy_usb_pending)
               || glb_set[`PMG_GLB_USB];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fw_rel_r <= 1'b0;
    else
      fw_rel_r <= (fw_rel_r && !glb_clr[`PMG_GLB_FW_REL])
                  || glb_set[`PMG_GLB_FW_REL];
  end

  // device monitor flags
  logic [13:0] trap_r;
  logic [11:0] idle_r;
  pmg_word_t   dev_flags;

  assign dev_clr = (io_wr && hit_dev) ? (io_wdata & wmask) : 32'h0000_0000;

  genvar gi;
  generate
    for (gi = 0; gi < `PMG_NUM_TRAP; gi++)
    begin : g_trap
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          trap_r[gi] <= 1'b0;
        else
          trap_r[gi] <= (trap_r[gi] && !dev_clr[`PMG_DEV_TRAP_LSB + gi])
                        || monitor_trap_evt[gi];
      end
    end
    for (gi = 0; gi < `PMG_NUM_IDLE; gi++)
    begin : g_idle
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          idle_r[gi] <= 1'b0;
        else
          idle_r[gi] <= (idle_r[gi] && !dev_clr[`PMG_DEV_IDLE_LSB + gi])
                        || monitor_idle_evt[gi];
      end
    end
  endgenerate

  // reserved bits 31:30 and 15:12 stay zero
  assign dev_flags = {2'b00, trap_r, 4'h0, idle_r};

  // global flag image with summaries
  logic [15:0] glb_flags;

  always_comb
  begin
    glb_flags = `PMG_RST_GLB;
    glb_flags[`PMG_GLB_IRQ_RSM] = irq_rsm_r;
    glb_flags[`PMG_GLB_EXT_EVT] = ext_evt_r;
    glb_flags[`PMG_GLB_STBY]    = stby_r;
    glb_flags[`PMG_GLB_GP_SUM]  = |general_purpose_status_reg;
    glb_flags[`PMG_GLB_PM_SUM]  = |pm_event_status_reg;
    glb_flags[`PMG_GLB_PWR_CMD] = pwr_cmd_r;
    glb_flags[`PMG_GLB_DEV_SUM] = |dev_flags;
    glb_flags[`PMG_GLB_MABORT]  = mabort_r;
    glb_flags[`PMG_GLB_USB]     = usb_r;
    glb_flags[`PMG_GLB_FW_REL]  = fw_rel_r;
  end

  // read data, one cycle after the read strobe
  pmg_word_t rdata_nxt;

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_glb)
      rdata_nxt = {16'h0000, glb_flags} & wmask;
    else if (hit_dev)
      rdata_nxt = dev_flags & wmask;
    else if (hit_entry)
      rdata_nxt = {24'h00_0000, `PMG_ENTRY_RDATA};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      io_rdata <= 32'h0000_0000;
    else if (io_rd)
      io_rdata <= rdata_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      io_rvalid <= 1'b0;
    else
      io_rvalid <= io_rd;
  end

  // clock control state
  pmg_cstate_t cstate_r;
  pmg_cstate_t cstate_nxt;

  // next clock state; entry reads act only from run
  always_comb
  begin
    cstate_nxt = cstate_r;
    unique case (cstate_r)
      PMG_RUN:
      begin
        if (rd_level2_clock_state)
          cstate_nxt = PMG_LEVEL2_CLOCK_STATE;
        else if (rd_level3_clock_state)
          cstate_nxt = PMG_LEVEL3_CLOCK_STATE;
      end
      PMG_LEVEL2_CLOCK_STATE:
      begin
        if (clock_ctrl_break)
          cstate_nxt = PMG_RUN;
      end
      PMG_LEVEL3_CLOCK_STATE:
      begin
        if (clock_ctrl_break)
          cstate_nxt = PMG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cstate_r <= PMG_RUN;
    else
      cstate_r <= cstate_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      level2_entry <= 1'b0;
      level3_entry <= 1'b0;
    end
    else
    begin
      level2_entry <= rd_level2_clock_state && cstate_r == PMG_RUN;
      level3_entry <= rd_level3_clock_state && cstate_r == PMG_RUN;
    end
  end

  assign level2_clock_state = cstate_r == PMG_LEVEL2_CLOCK_STATE;
  assign level3_clock_state = cstate_r == PMG_LEVEL3_CLOCK_STATE;
  assign host_clock_stop    = level3_clock_state
                              && host_clock_stop_enable;

endmodule : pmg_top

`default_nettype wire

// ---- verification/pmg_top_asserts.sv ----
// assertions on read timing and clock-control entry
`timescale 1ns/1ns
`default_nettype none
module pmg_top_asserts (
  // watched ports
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [7:0]         io_addr,
  input wire logic               io_rd,
  input wire logic               io_wr,
  input wire pmg_pkg::pmg_be_t   io_be,
  input wire pmg_pkg::pmg_word_t io_rdata,
  input wire logic               io_rvalid,
  input wire logic               clock_ctrl_enable,
  input wire logic               host_clock_stop_enable,
  input wire logic               clock_ctrl_break,
  input wire logic               level2_entry,
  input wire logic               level3_entry,
  input wire logic               level2_clock_state,
  input wire logic               level3_clock_state,
  input wire logic               host_clock_stop
);
  import pmg_pkg::*;
  wire logic ent = io_rd && io_addr[7:2] == 6'h05;
  wire logic go  = ent && clock_ctrl_enable && !clock_ctrl_break
    && !level2_clock_state && !level3_clock_state;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rv; io_rvalid == ($past(io_rd) && !$past(sys_rst)); endproperty
  a_rv: assert property (p_rv) else $error("read answer timing");
  property p_zero; ent |=> io_rdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("entry read not zero");
  property p_l2;
    go && io_be == 4'h1 |=> level2_entry && level2_clock_state ##1 !level2_entry;
  endproperty
  a_l2: assert property (p_l2) else $error("level2 entry missed");
  property p_l3;
    go && io_be == 4'h2 |=> level3_entry && level3_clock_state ##1 !level3_entry;
  endproperty
  a_l3: assert property (p_l3) else $error("level3 entry missed");
  property p_gate; level2_entry || level3_entry |-> $past(ent && clock_ctrl_enable); endproperty
  a_gate: assert property (p_gate) else $error("entry without enable");
  property p_wr;
    io_wr && !io_rd && io_addr[7:2] == 6'h05 && !clock_ctrl_break
      |=> $stable(level2_clock_state) && $stable(level3_clock_state);
  endproperty
  a_wr: assert property (p_wr) else $error("entry write acted");
  property p_stop; host_clock_stop == (level3_clock_state && host_clock_stop_enable); endproperty
  a_stop: assert property (p_stop) else $error("host clock stop wrong");
  property p_hi; io_rd && io_addr[7:2] == 6'h06 |=> io_rdata[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper status half not zero");
endmodule : pmg_top_asserts
bind pmg_top pmg_top_asserts i_pmg_top_asserts (.*);
`default_nettype wire

// ---- verification/pmg_top_test.sv ----
// random bench with a reference model of the block
`timescale 1ns/1ns
`default_nettype none
module pmg_top_test;
  import pmg_pkg::*;
  logic        clk, sys_rst, io_rd, io_wr, io_rvalid, e2, e3, s1, s2, s3;
  logic        clock_ctrl_enable, host_clock_stop_enable, clock_ctrl_break;
  logic        irq_resume_evt, external_mgmt_int_input_n, standby_expiry_evt;
  logic        power_command_evt, master_abort_evt, legacy_usb_evt, legacy_usb_pending;
  logic        global_release_wr, level2_entry, level3_entry, host_clock_stop;
  logic        level2_clock_state, level3_clock_state;
  logic [7:0]  io_addr, general_purpose_status_reg, pm_event_status_reg;
  logic [13:0] monitor_trap_evt;
  logic [11:0] monitor_idle_evt;
  pmg_be_t     io_be;
  pmg_word_t   io_wdata, io_rdata, g, d, lm, q[$];
  int          seed = 77, error_cnt = 0, check_count = 0, st = 0;
  pmg_top i_pmg_top (.*);
  task chk(input string n, input pmg_word_t e, s);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task drv(input logic r, w);
    io_rd = r;
    io_wr = w;
    io_addr = 8'h14 + 8'($unsigned($random(seed)) % 20);
    io_be = 4'($random(seed));
    io_wdata = $random(seed);
    {irq_resume_evt, standby_expiry_evt, power_command_evt, master_abort_evt, legacy_usb_evt,
      global_release_wr, monitor_trap_evt, monitor_idle_evt} = w ? $random(seed) & $random(seed) : 0;
    clock_ctrl_break = w && ($random(seed) & 3) == 0;
    if (w) {clock_ctrl_enable, host_clock_stop_enable, legacy_usb_pending,
      external_mgmt_int_input_n} = 4'($random(seed));
    if (w) general_purpose_status_reg = 8'($random(seed) & $random(seed) & $random(seed));
    if (w) pm_event_status_reg = 8'($random(seed) & $random(seed) & $random(seed));
  endtask : drv
  task cyc(input logic r, w);
    @(negedge clk);
    drv(r, w);
  endtask : cyc
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // reference model, one step per edge
  always @(posedge clk)
  begin
    lm = {{8{io_be[3]}}, {8{io_be[2]}}, {8{io_be[1]}}, {8{io_be[0]}}};
    if (io_rd)
      q.push_back(lm & (io_addr[7:2] == 6'h07 ? d : io_addr[7:2] != 6'h06 ? 32'h0 :
        g | {24'h0, |general_purpose_status_reg, |pm_event_status_reg, 1'b0, |d, 4'h0}));
    e2 = 0;
    e3 = 0;
    if (clock_ctrl_break)
      st = 0;
    else if (io_rd && io_addr[7:2] == 6'h05 && clock_ctrl_enable && st == 0)
    begin
      e2 = io_be == 4'h1;
      e3 = io_be == 4'h2;
      st = e2 ? 1 : e3 ? 2 : 0;
    end
    lm = io_wr ? lm & io_wdata : 32'h0;
    if (io_addr[7:2] == 6'h06) g &= ~(lm & 32'h0000_0D25);
    if (io_addr[7:2] == 6'h07) d &= ~(lm & 32'h3FFF_0FFF);
    g[1] = legacy_usb_evt | g[1] & legacy_usb_pending;
    g |= {20'h0, irq_resume_evt, s3 & !s2, 1'b0, standby_expiry_evt, 2'b0,
      power_command_evt, 2'b0, master_abort_evt, 1'b0, global_release_wr};
    d |= {2'b0, monitor_trap_evt, 4'h0, monitor_idle_evt};
    s3 = s2;
    s2 = s1;
    s1 = external_mgmt_int_input_n;
    if (sys_rst)
    begin
      {g, d, st, e2, e3} = 0;
      {s1, s2, s3} = 3'h7;
      q.delete();
    end
  end
  always @(negedge clk)
  begin
    #10;
    if (q.size() > 0)
    begin
      chk("io_rvalid", 1, io_rvalid);
      chk("io_rdata", q.pop_front(), io_rdata);
    end
    else
      chk("io_rvalid", 0, io_rvalid);
    chk("level2_entry", e2, level2_entry);
    chk("level3_entry", e3, level3_entry);
    chk("level2_clock_state", st == 1, level2_clock_state);
    chk("level3_clock_state", st == 2, level3_clock_state);
    chk("host_clock_stop", st == 2 && host_clock_stop_enable, host_clock_stop);
  end
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    drv(0, 1);
    external_mgmt_int_input_n = 1;
    sys_rst = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    repeat (6) cyc(1, 0);
    $display("test reset_values done");
    repeat (800)
    begin
      cyc(0, 1);
      cyc(1, 0);
      cyc(1, 0);
    end
    sys_rst = 1;
    repeat (2) cyc(1, 0);
    sys_rst = 0;
    repeat (6) cyc(1, 0);
    $display("test mid_run_reset done");
    cyc(0, 0);
    cyc(0, 0);
    $display("test random_traffic done");
    complete_run();
  end
endmodule : pmg_top_test
`default_nettype wire
